/* fsg_flash_model.sv */
// Purpose: Read port model of the flash array behind the signature engine.
// Assumes: Each word holds a fixed pattern built from its own index.
// Notes: Without a request the port shows the inverse, so stale data never folds in.
`timescale 1ns/1ps
module fsg_flash_model (
    input wire logic i_req,
    input wire logic [16:0] i_idx,
    output logic [127:0] o_data
);
    assign o_data = i_req ? {4{15'h5A3C, i_idx}} : ~{4{15'h5A3C, i_idx}};
endmodule : fsg_flash_model

/* fsg_pkg.sv */
// Purpose: Constants for the flash signature generator.
// Assumes: 32-bit register port, 128-bit flash words.
// Notes: Offsets are byte addresses on the register port.
package fsg_pkg;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_WAIT = 12'h010;
    localparam logic [11:0] OFF_FIRST = 12'h020;
    localparam logic [11:0] OFF_LAST = 12'h024;
    localparam logic [11:0] OFF_RES0 = 12'h02C;
    localparam logic [11:0] OFF_RES1 = 12'h030;
    localparam logic [11:0] OFF_RES2 = 12'h034;
    localparam logic [11:0] OFF_RES3 = 12'h038;
    localparam logic [11:0] OFF_STAT = 12'hFE0;
    localparam logic [11:0] OFF_CLR = 12'hFE8;
    localparam logic [31:0] CTRL_RESET = 32'h00020005;
    localparam logic [31:0] WAIT_RESET = 32'h0000C005;
    localparam int WORD_W = 128;
    localparam int REG_W = 32;
    localparam int IDX_W = 17;
    localparam int WAIT_W = 8;
    localparam int LAUNCH_BIT = 17;
    localparam int DONE_BIT = 2;
    localparam int TAP_A = 0;
    localparam int TAP_B = 2;
    localparam int TAP_C = 27;
    localparam int TAP_D = 29;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_FOLD = 3'b100
    } fsg_state_type;
endpackage : fsg_pkg

/* fsg_top.sv */
// Purpose: Flash signature engine with register port and flash read port.
// Assumes: Single clock, flash data returned combinationally per request.
// Notes: Read data stand the cycle after a read strobe.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module fsg_top
    import fsg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_flash_req,
    output logic [IDX_W-1:0] o_flash_idx,
    input wire logic [WORD_W-1:0] i_flash_data,
    output logic o_other_stall,
    output logic o_busy
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [WAIT_W-1:0] wait_r;
    logic [23:0] wait_hi_r;
    logic [IDX_W-1:0] first_r;
    logic [IDX_W-1:0] last_r;
    logic launch_r;
    logic done_r;
    logic [WORD_W-1:0] sig_r;
    logic [IDX_W-1:0] idx_r;
    logic [WAIT_W-1:0] cnt_r;
    fsg_state_type state_r;
    logic finish;
    logic wr_last;
    logic launch_wr;
    logic clr_wr;

    function automatic logic [WORD_W-1:0] fold(input logic [WORD_W-1:0] s,
                                                input logic [WORD_W-1:0] d);
        logic [WORD_W-1:0] n;
        n = d ^ {1'b0, s[WORD_W-1:1]};
        n[WORD_W-1] = d[WORD_W-1] ^ s[TAP_A] ^ s[TAP_B] ^ s[TAP_C] ^ s[TAP_D];
        return n;
    endfunction : fold

    // Address decode is shared by the register, engine and check logic.
    function automatic logic reg_hit(input logic strobe,
                                     input logic [11:0] addr,
                                     input logic [11:0] offset);
        return strobe && (addr == offset);
    endfunction : reg_hit

    // Result word k holds signature bits 32k+31 down to 32k, lowest offset first.
    function automatic logic [REG_W-1:0] result_word(input logic [WORD_W-1:0] s,
                                                      input int k);
        return s[k*REG_W +: REG_W];
    endfunction : result_word

    assign wr_last = reg_hit(i_wr, i_addr, OFF_LAST);
    assign launch_wr = wr_last && i_wdata[LAUNCH_BIT];
    assign clr_wr = reg_hit(i_wr, i_addr, OFF_CLR) && i_wdata[DONE_BIT];
    assign finish = (state_r == ST_FOLD) && (idx_r == last_r);

    // Reserved control and wait bits keep whatever software wrote, so that a
    // read-modify-write of the read mode bits leaves the rest untouched.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_r <= CTRL_RESET;
            wait_r <= WAIT_RESET[WAIT_W-1:0];
            wait_hi_r <= WAIT_RESET[31:WAIT_W];
            first_r <= '0;
        end else if (i_wr) begin
            if (i_addr == OFF_CTRL) ctrl_r <= i_wdata;
            if (i_addr == OFF_WAIT) begin
                wait_r <= i_wdata[WAIT_W-1:0];
                wait_hi_r <= i_wdata[31:WAIT_W];
            end
            if (i_addr == OFF_FIRST) first_r <= i_wdata[IDX_W-1:0];
        end
    end

    // Launch bit: written by software, cleared by hardware with done.
    // A launch write during a run is dropped whole, index included, so the
    // run in flight keeps the range it started with.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            last_r <= '0;
            launch_r <= 1'b0;
        end else begin
            if (wr_last && state_r == ST_IDLE) begin
                last_r <= i_wdata[IDX_W-1:0];
                launch_r <= i_wdata[LAUNCH_BIT];
            end else if (finish) begin
                launch_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Engine
    // ----------------------------------------------------------------
    // Wait count uses only wait_r; there is no normal access-time input.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            cnt_r <= '0;
            sig_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (launch_wr) begin
                        state_r <= ST_WAIT;
                        idx_r <= first_r;
                        cnt_r <= wait_r;
                        sig_r <= '0;
                    end
                end
                ST_WAIT: begin
                    if (cnt_r == '0) state_r <= ST_FOLD;
                    else cnt_r <= cnt_r - 1'b1;
                end
                // The word folds only after its wait count, so slow flash data has settled.
                ST_FOLD: begin
                    sig_r <= fold(sig_r, i_flash_data);
                    if (finish) begin
                        state_r <= ST_IDLE;
                    end else begin
                        idx_r <= idx_r + 1'b1;
                        cnt_r <= wait_r;
                        state_r <= ST_WAIT;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Done is sticky; a completion in the clearing cycle wins.
    // Software should clear it before each launch, or a leftover flag reads as done.
    always_ff @(posedge i_mclk) begin
        if (i_rst) done_r <= 1'b0;
        else if (finish) done_r <= 1'b1;
        else if (clr_wr) done_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Flash port and read data
    // ----------------------------------------------------------------
    // Stall rises the cycle after the launch write, one cycle before the first flash request, so no other read can slip in
    // between the launch write and the first signature read.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_flash_req <= 1'b0;
            o_flash_idx <= '0;
            o_other_stall <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_flash_req <= (state_r != ST_IDLE) && !finish;
            o_flash_idx <= (state_r == ST_IDLE) ? first_r : idx_r;
            o_other_stall <= (state_r != ST_IDLE || (wr_last && i_wdata[LAUNCH_BIT]))
                             && !finish;
            o_busy <= (state_r != ST_IDLE || (wr_last && i_wdata[LAUNCH_BIT])) && !finish;
        end
    end

    // Read data are zero outside the cycle after a read, so stale words never look valid.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                OFF_CTRL: o_rdata <= ctrl_r;
                OFF_WAIT: o_rdata <= {wait_hi_r, wait_r};
                OFF_FIRST: o_rdata <= {15'h0000, first_r};
                OFF_LAST: o_rdata <= {14'h0000, launch_r, last_r};
                OFF_RES0: o_rdata <= result_word(sig_r, 0);
                OFF_RES1: o_rdata <= result_word(sig_r, 1);
                OFF_RES2: o_rdata <= result_word(sig_r, 2);
                OFF_RES3: o_rdata <= result_word(sig_r, 3);
                OFF_STAT: o_rdata <= {29'h00000000, done_r, 2'h0};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    // Counts the waiting cycles of the current word, so the wait length can be
    // checked for any programmed count, not only for one that a repetition fits.
    logic [WAIT_W:0] wait_seen_r;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wait_seen_r <= '0;
        end else if (state_r == ST_WAIT) begin
            wait_seen_r <= wait_seen_r + 1'b1;
        end else begin
            wait_seen_r <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_done_with_launch: assert property (@(posedge i_mclk) disable iff (i_rst)
        finish |=> done_r && !launch_r) else $error("done or launch wrong at end");
    a_done_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
        done_r && !(i_wr && i_addr == OFF_CLR && i_wdata[DONE_BIT]) |=> done_r)
        else $error("done dropped");
    a_clear_works: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_wr && i_addr == OFF_CLR && i_wdata[DONE_BIT] && !finish |=> !done_r)
        else $error("clear ignored");
    a_stall_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_WAIT |=> o_other_stall) else $error("no stall");
    // The repetition below is the reset wait count of five plus one.
    a_wait_len: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && wr_last && i_wdata[LAUNCH_BIT] && wait_r == WAIT_RESET[WAIT_W-1:0]
        |=> (state_r == ST_WAIT) [*6] ##1 state_r == ST_FOLD) else $error("wait count");
    a_idx_step: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_FOLD && !finish |=> idx_r == $past(idx_r) + 1'b1)
        else $error("index step");
    a_start_index: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && wr_last && i_wdata[LAUNCH_BIT] |=> idx_r == $past(first_r))
        else $error("start index");
    a_last_taken: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && wr_last |=> last_r == $past(i_wdata[IDX_W-1:0]))
        else $error("last index");
    a_sig_stable: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && !(wr_last && i_wdata[LAUNCH_BIT]) |=> $stable(sig_r))
        else $error("signature moved");
    a_run_ends: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_FOLD && idx_r == last_r
        |=> state_r == ST_IDLE && !o_busy && !o_flash_req && !o_other_stall)
        else $error("run did not end");

    // ----------------------------------------------------------------
    // Engine and port checks
    // ----------------------------------------------------------------
    a_wait_count: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_FOLD |-> wait_seen_r == {1'b0, wait_r} + 1'b1)
        else $error("wait length");
    a_fold_index: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_FOLD |-> o_flash_req && o_flash_idx == idx_r)
        else $error("fold reads wrong word");
    a_req_in_run: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_WAIT |=> o_flash_req)
        else $error("no flash request");
    a_busy_launch: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && launch_wr |=> o_busy && o_other_stall)
        else $error("launch without stall");
    a_stall_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && !launch_wr |=> !o_busy && !o_other_stall)
        else $error("stall while idle");
    a_sig_zeroed: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r == ST_IDLE && launch_wr |=> sig_r == '0)
        else $error("signature not cleared");
    a_launch_refused: assert property (@(posedge i_mclk) disable iff (i_rst)
        state_r != ST_IDLE && wr_last |=> $stable(last_r))
        else $error("index moved during run");

    // ----------------------------------------------------------------
    // Register port checks
    // ----------------------------------------------------------------
    a_stat_read: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && i_addr == OFF_STAT |=> o_rdata[DONE_BIT] == $past(done_r))
        else $error("status read");
    a_rdata_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_rd |=> o_rdata == '0)
        else $error("read data outside read");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    c_launch: cover property (@(posedge i_mclk) state_r == ST_IDLE && wr_last
        && i_wdata[LAUNCH_BIT]);
    c_finish: cover property (@(posedge i_mclk) finish);
    c_clear: cover property (@(posedge i_mclk) done_r ##1 !done_r);
    c_multi: cover property (@(posedge i_mclk) state_r == ST_FOLD && !finish);
    c_default_wait: cover property (@(posedge i_mclk) state_r == ST_IDLE && launch_wr
        && wait_r == WAIT_RESET[WAIT_W-1:0]);
endmodule : fsg_top

/* fsg_top_tb.sv */
// Purpose: Self-checking bench for the flash signature generator.
// Assumes: The flash model answers in the same cycle as the index.
// Notes: Expected signatures are folded here from the word pattern.
`timescale 1ns/1ps
module fsg_top_tb;
    import fsg_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h00000000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_flash_req;
    logic [IDX_W-1:0] o_flash_idx;
    logic [WORD_W-1:0] i_flash_data;
    logic o_other_stall;
    logic o_busy;
    logic [127:0] sig;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #12.5 i_mclk = ~i_mclk;
    fsg_top fsg_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_req(o_flash_req),
        .o_flash_idx(o_flash_idx), .i_flash_data(i_flash_data),
        .o_other_stall(o_other_stall), .o_busy(o_busy));
    fsg_flash_model fsg_flash_model_inst (.i_req(o_flash_req), .i_idx(o_flash_idx),
        .o_data(i_flash_data));
    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp, what);
    endtask : rd
    // One run: busy spans wait+2 cycles per word, and every cycle of it stalls others.
    task automatic run(input logic [7:0] w, input int f, input int l, output logic [127:0] s);
        logic [127:0] d;
        int busy_n;
        int stall_n;
        s = '0;
        for (int i = f; i <= l; i++) begin
            d = {4{15'h5A3C, i[16:0]}};
            s = {d[127] ^ s[0] ^ s[2] ^ s[27] ^ s[29], d[126:0] ^ s[127:1]};
        end
        wr(OFF_CLR, 32'h00000004);
        rd(OFF_STAT, 32'h00000000, "status cleared");
        wr(OFF_WAIT, {24'h0000C0, w});
        wr(OFF_FIRST, {15'h0000, f[16:0]});
        wr(OFF_LAST, {14'h0000, 1'b1, l[16:0]});
        busy_n = 0;
        stall_n = 0;
        #1;
        while (o_busy === 1'b1 && busy_n < 2000) begin
            if (o_other_stall === 1'b1) stall_n++;
            busy_n++;
            @(posedge i_mclk);
            #1;
        end
        chk(32'(busy_n), 32'((w + 2) * (l - f + 1)), "busy cycles");
        chk(32'(stall_n), 32'(busy_n), "stall cycles");
        rd(OFF_STAT, 32'h00000004, "done flag");
        rd(OFF_LAST, {15'h0000, l[16:0]}, "launch cleared");
        rd(OFF_RES0, s[31:0], "result 0");
        rd(OFF_RES1, s[63:32], "result 1");
        rd(OFF_RES2, s[95:64], "result 2");
        rd(OFF_RES3, s[127:96], "result 3");
    endtask : run
    // A launch write that lands during a run must neither relaunch nor move the index.
    task automatic refuse;
        wr(OFF_WAIT, 32'h0000C010);
        wr(OFF_FIRST, 32'h00000000);
        wr(OFF_LAST, 32'h00020002);
        wr(OFF_LAST, 32'h00020009);
        rd(OFF_LAST, 32'h00020002, "launch while busy");
        repeat (60) @(posedge i_mclk);
        rd(OFF_LAST, 32'h00000002, "refused run ended");
        rd(OFF_STAT, 32'h00000004, "done after refused launch");
        wr(OFF_LAST, 32'h00000007);
        rd(OFF_LAST, 32'h00000007, "index without launch");
        chk({31'h00000000, o_busy}, 32'h00000000, "no run without launch");
    endtask : refuse
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(OFF_CTRL, CTRL_RESET, "ctrl reset");
        rd(OFF_WAIT, WAIT_RESET, "wait reset");
        rd(OFF_FIRST, 32'h00000000, "first reset");
        rd(OFF_LAST, 32'h00000000, "last reset");
        rd(OFF_STAT, 32'h00000000, "status reset");
        rd(OFF_CLR, 32'h00000000, "clear reads zero");
        rd(12'h100, 32'h00000000, "unmapped read");
        wr(OFF_CTRL, 32'h00020015);
        rd(OFF_CTRL, 32'h00020015, "ctrl readback");
        run(8'h02, 3, 5, sig);
        wr(OFF_CLR, 32'h00000000);
        rd(OFF_STAT, 32'h00000004, "zero clear ignored");
        wr(OFF_RES0, ~sig[31:0]);
        rd(OFF_RES0, sig[31:0], "result read only");
        run(8'h00, 17'h1FFFF, 17'h1FFFF, sig);
        run(WAIT_RESET[WAIT_W-1:0], 0, 1, sig);
        refuse;
        finish_test;
    end
endmodule : fsg_top_tb
